// ===== design/dar_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef DAR_MAP_SVH
`define DAR_MAP_SVH

// ****************************************
// Register offsets
// ****************************************
`define DAR_A_GAIN_LO 5'h00
`define DAR_A_GAIN_HI 5'h01
`define DAR_A_CTL 5'h02
`define DAR_A_TGT 5'h03
`define DAR_A_DEXP 5'h04
`define DAR_A_AMAX 5'h05
`define DAR_A_AMIN 5'h06
`define DAR_A_STHR 5'h07
`define DAR_A_FMT 5'h08
`define DAR_A_PCK0 5'h09
`define DAR_A_GAIN_RD 5'h0D
`define DAR_A_STAT 5'h0E

// ****************************************
// Field positions
// ****************************************
`define DAR_CTL_FREEZE 0
`define DAR_CTL_GSYNC 1
`define DAR_CTL_CPLX 2
`define DAR_CTL_ZTHR 7:4
`define DAR_CTL_ZMASK 15:8
`define DAR_TGT_THR 7:0
`define DAR_TGT_MAX 15:8
`define DAR_D_BLW 3:0
`define DAR_D_ABV 7:4
`define DAR_D_ZRO 11:8
`define DAR_D_SAT 15:12
`define DAR_FMT_MODE 1:0
`define DAR_FMT_PINS 3:2
`define DAR_FMT_BITS 6:4
`define DAR_FMT_PREC 11:7
`define DAR_FMT_EMB 12
`define DAR_FMT_SPLIT 13
`define DAR_PCK_DIV 7:0
`define DAR_PCK_POL 8

// ****************************************
// Reset values and timing counts
// ****************************************
`define DAR_RST_GAIN_LO 16'h1000
`define DAR_RST_GAIN 19'h01000
`define DAR_RST_CTL 16'hFF0F
`define DAR_RST_TGT 16'hF040
`define DAR_RST_DEXP 16'h2244
`define DAR_RST_AMAX 16'hFFFF
`define DAR_RST_AMIN 16'hFFFF
`define DAR_RST_STHR 4'h8
`define DAR_RST_FMT 16'h0A48
`define DAR_RST_PCK 9'h003
`define DAR_SCK_VALID_CYC 3'h6
`define DAR_PREC_MIN 5'h04
`define DAR_PREC_MAX 5'h14
`define DAR_D_OFS 5'h03

`endif

// ===== design/dar_pkg.sv
// Types shared by the receive back end
package dar_pkg;

  typedef struct packed {
    logic [19:0] i;
    logic [19:0] q;
  } dar_iq_s;

  typedef enum logic [1:0] {
    DAR_FMT_PAR = 2'b00,
    DAR_FMT_INT = 2'b01,
    DAR_FMT_TDM = 2'b10
  } dar_fmt_e;

  typedef enum logic [1:0] {
    DAR_PST_IDLE = 2'b01,
    DAR_PST_SEND = 2'b10
  } dar_pst_e;

endpackage

// ===== design/dar_top.sv
// Gain loop, rounding and four formatted output ports of one receive channel
//
// Function
// RULE1: Multiply each 20-bit filter sample by the 19-bit combined gain word.
// RULE2: Gain is unsigned 7.12 fixed point; below 4096 means attenuation.
// RULE3: Compare output magnitude with target; decrease gain if above, else increase.
// RULE4: Applied gain is default plus adjustment; step is gain shifted by D+3.
// RULE5: Four step exponents: below, above, near-zero, saturated; chosen per sample.
// RULE6: Masked 8-bit magnitude drives 4-bit up/down zero counter against threshold.
// RULE7: Count samples above maximum magnitude; past threshold use saturation exponent.
// RULE8: Adjustment stops rising above upper limit, stops falling below negated lower.
// RULE9: Adapt only on valid samples; I and Q each get their own step.
// RULE10: Freeze bit holds the adjustment unchanged.
// RULE11: Gain sync clears adjustment and loads programmed gain.
// RULE12: Parallel, interleaved I-first, or time-multiplexed output on port D.
// RULE13: Four ports, each with 16 data pins, divided clock and frame strobe.
// RULE14: Port clock is main clock over divide plus one, polarity selectable.
// RULE15: Receiver samples on falling edge for polarity 0, rising for 1.
// RULE16: Port clock valid six main-clock cycles after the port sync event.
// RULE17: Frame strobe high one port period with first chunk of first I word; split time-multiplexed mode strobes with port D's Q word instead.
// RULE18: Frame period may alternate X and X+1 periods when ratios do not divide.
// RULE19: Pins 4, 8 or 16; word 4 to 20 bits; wide words sent MSB first.
// RULE20: Round to 4..20 bits of precision, unused low bits zero.
// RULE21: Receiver counts successive words after each frame strobe itself.
// RULE22: Configuration should leave at least one idle clock in multiplexed frames.
// RULE23: Saturate scaled data, then round half to even into upper bits.
// RULE24: Embedded gain replaces low 8 bits of 16-bit words when rounding to 8 or less.
// RULE25: Reset clears adjustment and counters and holds port outputs low.
`timescale 1ns/1ps
`include "dar_map.svh"

module dar_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [19:0] sample_in,
  input wire logic sample_valid,
  input wire logic sample_is_q,
  input wire dar_pkg::dar_iq_s peer_b,
  input wire dar_pkg::dar_iq_s peer_c,
  input wire dar_pkg::dar_iq_s peer_d,
  input wire logic gain_sync_pin,
  input wire logic sck_sync_pin,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata,
  output wire logic [15:0] port_a_data_out,
  output wire logic [15:0] port_b_data_out,
  output wire logic [15:0] port_c_data_out,
  output wire logic [15:0] port_d_data_out,
  output wire logic [3:0] port_divided_clock,
  output wire logic [3:0] port_frame_strobe
);
  import dar_pkg::*;

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic [4:0] pins_n(input logic [1:0] c);
    pins_n = (c == 2'h0) ? 5'h04 : (c == 2'h1) ? 5'h08 : 5'h10;
  endfunction

  function automatic logic [4:0] bits_n(input logic [2:0] c);
    bits_n = (c > 3'h3) ? 5'h14 : 5'({c, 2'b00} + 5'h04);
  endfunction

  function automatic logic [2:0] n_chunks(input logic [2:0] bc, input logic [1:0] pc);
    logic [5:0] t;
    begin
      t = 6'(bits_n(bc)) + 6'(pins_n(pc)) - 6'h01;
      n_chunks = 3'(t / 6'(pins_n(pc)));
    end
  endfunction

  function automatic logic [3:0] n_words(input logic [1:0] m, input logic s, input logic [1:0] p);
    n_words = (m == DAR_FMT_TDM) ? ((p == 2'h3) ? (s ? 4'h4 : 4'h8) : 4'h0) :
              (m == DAR_FMT_INT) ? 4'h2 : 4'h1;
  endfunction

  // Time-multiplexed order walks D down to A, I before Q; split mode alternates Q/I
  function automatic logic [19:0] word_of(input dar_iq_s [3:0] ch, input logic [1:0] m,
                                          input logic s, input logic [1:0] p,
                                          input logic [3:0] idx);
    logic [1:0] c;
    logic q;
    begin
      c = p;
      q = idx[0];
      if (m == DAR_FMT_TDM)
      begin
        c = s ? 2'h3 - idx[1:0] : 2'h3 - idx[2:1];
        q = s ? ~idx[0] : idx[0];
      end
      word_of = q ? ch[c].q : ch[c].i;
    end
  endfunction

  // Chunks leave the word MSB first and sit on the low pins of the port
  function automatic logic [15:0] chunk(input logic [19:0] w, input logic [2:0] idx,
                                        input logic [1:0] pc, input logic [2:0] bc);
    logic [19:0] wm;
    logic [19:0] sh;
    begin
      wm = w & ~(20'hFFFFF >> bits_n(bc));
      sh = wm << (idx * pins_n(pc));
      chunk = (pc == 2'h2) ? sh[19:4] : (pc == 2'h1) ? {8'h00, sh[19:12]} : {12'h000, sh[19:16]};
    end
  endfunction

  // Ties add half minus one plus the kept LSB, so halves go to the even neighbour
  function automatic logic [19:0] rnd_even(input logic [19:0] x, input logic [4:0] k);
    logic [20:0] s;
    logic [20:0] m;
    begin
      rnd_even = x;
      if (k != 5'h00)
      begin
        m = ~((21'h000001 << k) - 21'h000001);
        s = {x[19], x} + ((21'h000001 << (k - 5'h01)) - 21'h000001) + {20'h00000, x[k]};
        s = s & m;
        rnd_even = (s[20] != s[19]) ? (20'h7FFFF & m[19:0]) : s[19:0];
      end
    end
  endfunction

  // ****************************************
  // Register file
  // ****************************************
  logic [15:0] gain_lo_ff, ctl_ff, tgt_ff, dexp_ff, amax_ff, amin_ff, fmt_ff;
  logic [2:0] gain_hi_ff;
  logic [3:0] sthr_ff;
  logic [8:0] pck_ff [4];
  logic [18:0] g_ff;
  logic signed [20:0] adj_ff;
  logic [3:0] zcnt_ff, scnt_ff;
  logic [18:0] gt;
  logic zero_st, sat_st;
  logic [15:0] nxt_rdata;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      gain_lo_ff <= `DAR_RST_GAIN_LO;
      gain_hi_ff <= 3'h0;
      ctl_ff <= `DAR_RST_CTL;
      tgt_ff <= `DAR_RST_TGT;
      dexp_ff <= `DAR_RST_DEXP;
      amax_ff <= `DAR_RST_AMAX;
      amin_ff <= `DAR_RST_AMIN;
      sthr_ff <= `DAR_RST_STHR;
      fmt_ff <= `DAR_RST_FMT;
      for (int i = 0; i < 4; i++) pck_ff[i] <= `DAR_RST_PCK;
      reg_rdata <= 16'h0000;
    end
    else
    begin
      if (reg_we && reg_addr == `DAR_A_GAIN_LO) gain_lo_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_GAIN_HI) gain_hi_ff <= reg_wdata[2:0];
      if (reg_we && reg_addr == `DAR_A_CTL) ctl_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_TGT) tgt_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_DEXP) dexp_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_AMAX) amax_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_AMIN) amin_ff <= reg_wdata;
      if (reg_we && reg_addr == `DAR_A_STHR) sthr_ff <= reg_wdata[3:0];
      if (reg_we && reg_addr == `DAR_A_FMT) fmt_ff <= reg_wdata;
      for (int i = 0; i < 4; i++)
        if (reg_we && reg_addr == `DAR_A_PCK0 + 5'(i)) pck_ff[i] <= reg_wdata[8:0];
      reg_rdata <= reg_re ? nxt_rdata : 16'h0000;
    end
  end

  wire [4:0] ra_pck = reg_addr - `DAR_A_PCK0;
  wire ra_is_pck = reg_addr >= `DAR_A_PCK0 && reg_addr < `DAR_A_GAIN_RD;
  assign nxt_rdata = (reg_addr == `DAR_A_GAIN_LO) ? gain_lo_ff :
                     (reg_addr == `DAR_A_GAIN_HI) ? {13'h000, gain_hi_ff} :
                     (reg_addr == `DAR_A_CTL) ? ctl_ff :
                     (reg_addr == `DAR_A_TGT) ? tgt_ff :
                     (reg_addr == `DAR_A_DEXP) ? dexp_ff :
                     (reg_addr == `DAR_A_AMAX) ? amax_ff :
                     (reg_addr == `DAR_A_AMIN) ? amin_ff :
                     (reg_addr == `DAR_A_STHR) ? {12'h000, sthr_ff} :
                     (reg_addr == `DAR_A_FMT) ? fmt_ff :
                     ra_is_pck ? {7'h00, pck_ff[ra_pck[1:0]]} :
                     (reg_addr == `DAR_A_GAIN_RD) ? gt[18:3] :
                     (reg_addr == `DAR_A_STAT) ? {zcnt_ff, scnt_ff, 6'h00, sat_st, zero_st} :
                     16'h0000;

  // ****************************************
  // Sync pins
  // ****************************************
  logic [2:0] gsy_ff, ssy_ff;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      gsy_ff <= 3'h0;
      ssy_ff <= 3'h0;
    end
    else
    begin
      gsy_ff <= {gsy_ff[1:0], gain_sync_pin};
      ssy_ff <= {ssy_ff[1:0], sck_sync_pin};
    end
  end

  wire gsync = ctl_ff[`DAR_CTL_GSYNC] | (gsy_ff[1] & ~gsy_ff[2]);
  wire sck_evt = ssy_ff[1] & ~ssy_ff[2];

  // ****************************************
  // Gain multiply and saturation
  // ****************************************
  wire signed [21:0] gsum = $signed({3'b000, g_ff}) + $signed({adj_ff[20], adj_ff}); // [RULE4]
  assign gt = gsum[21] ? 19'h00000 : (gsum[20:19] != 2'b00) ? 19'h7FFFF : gsum[18:0]; // [RULE2]
  wire signed [39:0] prod = $signed(sample_in) * $signed({1'b0, gt}); // [RULE1]
  // Dropping 12 fraction bits; the sign extension check decides saturation
  wire fits = (prod[39:31] == {9{prod[39]}});
  wire [19:0] scaled = fits ? prod[31:12] : (prod[39] ? 20'h80000 : 20'h7FFFF); // [RULE23]

  logic [19:0] s1_d_ff, r_d_ff, held_i_ff;
  logic s1_v_ff, s1_q_ff, r_v_ff, r_q_ff;

  // ****************************************
  // Rounding and magnitude
  // ****************************************
  wire [4:0] prec_raw = fmt_ff[`DAR_FMT_PREC];
  wire [4:0] prec = (prec_raw < `DAR_PREC_MIN) ? `DAR_PREC_MIN :
                    (prec_raw > `DAR_PREC_MAX) ? `DAR_PREC_MAX : prec_raw;
  wire [19:0] rnd = rnd_even(s1_d_ff, `DAR_PREC_MAX - prec); // [RULE20] [RULE23]
  wire [19:0] rabs = rnd[19] ? 20'(~rnd + 20'h00001) : rnd;
  wire [7:0] mag = rabs[19] ? 8'hFF : rabs[18:11];

  // ****************************************
  // Adaptive loop
  // ****************************************
  wire above = mag > tgt_ff[`DAR_TGT_THR]; // [RULE3]
  assign zero_st = zcnt_ff > ctl_ff[`DAR_CTL_ZTHR]; // [RULE6]
  assign sat_st = scnt_ff > sthr_ff; // [RULE7]
  // Extreme states take priority so the fast constants pull the loop back first
  wire [3:0] dsel = sat_st ? dexp_ff[`DAR_D_SAT] : zero_st ? dexp_ff[`DAR_D_ZRO] :
                    above ? dexp_ff[`DAR_D_ABV] : dexp_ff[`DAR_D_BLW]; // [RULE5]
  wire [20:0] step = {2'b00, gt} >> ({1'b0, dsel} + `DAR_D_OFS); // [RULE4]
  wire signed [20:0] lim_hi = $signed({2'b00, amax_ff, 3'b000});
  wire signed [20:0] lim_lo = -$signed({2'b00, amin_ff, 3'b000});
  wire up_ok = !(adj_ff > lim_hi); // [RULE8]
  wire dn_ok = !(adj_ff < lim_lo); // [RULE8]
  wire adapt = s1_v_ff && !ctl_ff[`DAR_CTL_FREEZE]; // [RULE9] [RULE10]
  wire signed [20:0] nxt_adj = gsync ? 21'sh00000 : // [RULE11]
                               !adapt ? adj_ff :
                               above ? (dn_ok ? adj_ff - $signed(step) : adj_ff) :
                               (up_ok ? adj_ff + $signed(step) : adj_ff); // [RULE3]
  wire zhit = (mag & ctl_ff[`DAR_CTL_ZMASK]) == 8'h00;
  wire shit = mag > tgt_ff[`DAR_TGT_MAX];
  wire [3:0] nxt_zcnt = zhit ? ((zcnt_ff == 4'hF) ? zcnt_ff : zcnt_ff + 4'h1) :
                        ((zcnt_ff == 4'h0) ? zcnt_ff : zcnt_ff - 4'h1);
  wire [3:0] nxt_scnt = shit ? ((scnt_ff == 4'hF) ? scnt_ff : scnt_ff + 4'h1) :
                        ((scnt_ff == 4'h0) ? scnt_ff : scnt_ff - 4'h1);

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      g_ff <= `DAR_RST_GAIN;
      adj_ff <= 21'sh00000; // [RULE25]
      zcnt_ff <= 4'h0;
      scnt_ff <= 4'h0;
      s1_d_ff <= 20'h00000;
      s1_v_ff <= 1'b0;
      s1_q_ff <= 1'b0;
      r_d_ff <= 20'h00000;
      r_v_ff <= 1'b0;
      r_q_ff <= 1'b0;
    end
    else
    begin
      if (gsync) g_ff <= {gain_hi_ff, gain_lo_ff}; // [RULE11]
      adj_ff <= nxt_adj;
      if (s1_v_ff) zcnt_ff <= nxt_zcnt; // [RULE6]
      if (s1_v_ff) scnt_ff <= nxt_scnt; // [RULE7]
      s1_d_ff <= scaled;
      s1_v_ff <= sample_valid;
      s1_q_ff <= sample_is_q;
      r_d_ff <= rnd;
      r_v_ff <= s1_v_ff;
      r_q_ff <= s1_q_ff;
    end
  end

  // ****************************************
  // Word pairing and embedded gain
  // ****************************************
  wire [2:0] bc = fmt_ff[`DAR_FMT_BITS];
  wire [1:0] pc = fmt_ff[`DAR_FMT_PINS];
  wire [1:0] mode = fmt_ff[`DAR_FMT_MODE];
  wire split = fmt_ff[`DAR_FMT_SPLIT];
  wire cplx = ctl_ff[`DAR_CTL_CPLX];
  wire [2:0] nchk = n_chunks(bc, pc);
  wire emb = fmt_ff[`DAR_FMT_EMB] && bits_n(bc) == 5'h10 && prec <= 5'h08; // [RULE24]
  wire [19:0] w_i = emb ? {r_d_ff[19:12], gt[18:11], 4'h0} : r_d_ff; // [RULE24]
  wire [19:0] w_q = emb ? {r_d_ff[19:12], gt[10:5], zero_st, sat_st, 4'h0} : r_d_ff;
  wire new_pair = r_v_ff && (!cplx || r_q_ff);
  dar_iq_s own_pair;
  dar_iq_s [3:0] chans_ff;
  assign own_pair = cplx ? '{i: held_i_ff, q: w_q} : '{i: w_i, q: 20'h00000};

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      held_i_ff <= 20'h00000;
      chans_ff <= '0;
    end
    else
    begin
      if (r_v_ff && cplx && !r_q_ff) held_i_ff <= w_i; // [RULE9]
      if (new_pair) chans_ff <= {peer_d, peer_c, peer_b, own_pair};
    end
  end

  // ****************************************
  // Output ports
  // ****************************************
  for (genvar gp = 0; gp < 4; gp++)
  begin : g_port
    logic [7:0] cnt_ff;
    logic [2:0] vcnt_ff;
    logic pend_ff;
    dar_pst_e st_ff;
    logic [3:0] widx_ff;
    logic [2:0] cidx_ff;
    dar_iq_s [3:0] frm_ff;
    logic [15:0] data_ff;
    logic ck_ff;
    logic fs_ff;
    dar_iq_s [3:0] src;

    wire [7:0] div = pck_ff[gp][`DAR_PCK_DIV];
    wire pol = pck_ff[gp][`DAR_PCK_POL];
    wire tick = cnt_ff == div; // [RULE14]
    wire [7:0] nxt_cnt = (tick || sck_evt) ? 8'h00 : cnt_ff + 8'h01;
    wire valid = vcnt_ff == `DAR_SCK_VALID_CYC; // [RULE16]
    wire [3:0] nwd = n_words(mode, split, 2'(gp)); // [RULE12]
    wire last_c = cidx_ff == nchk - 3'h1;
    wire last_w = widx_ff == nwd - 4'h1;
    wire busy = st_ff == DAR_PST_SEND && !(last_c && last_w);
    // A waiting sample only starts on a period boundary, hence X or X+1 periods
    wire start = tick && valid && pend_ff && !busy && nwd != 4'h0; // [RULE18]
    wire [2:0] nxt_cidx = (start || last_c) ? 3'h0 : cidx_ff + 3'h1; // [RULE19]
    wire [3:0] nxt_widx = start ? 4'h0 : last_c ? widx_ff + 4'h1 : widx_ff;
    assign src = start ? chans_ff : frm_ff;
    wire [15:0] nxt_data = chunk(word_of(src, mode, split, 2'(gp), nxt_widx),
                                 nxt_cidx, pc, bc); // [RULE19]

    always_ff @(posedge mclk or posedge reset)
    begin
      if (reset)
      begin
        cnt_ff <= 8'h00;
        vcnt_ff <= 3'h0;
        pend_ff <= 1'b0;
        st_ff <= DAR_PST_IDLE;
        widx_ff <= 4'h0;
        cidx_ff <= 3'h0;
        frm_ff <= '0;
        data_ff <= 16'h0000; // [RULE25]
        ck_ff <= 1'b0;
        fs_ff <= 1'b0;
      end
      else
      begin
        cnt_ff <= nxt_cnt;
        if (sck_evt) vcnt_ff <= 3'h0;
        else if (!valid) vcnt_ff <= vcnt_ff + 3'h1; // [RULE16]
        pend_ff <= new_pair | (pend_ff & ~start);
        // Clock edge rises with the data change; polarity flips which edge that is
        ck_ff <= valid & ((nxt_cnt <= (div >> 1)) ^ pol); // [RULE14]
        if (!valid)
        begin
          st_ff <= DAR_PST_IDLE;
          data_ff <= 16'h0000; // [RULE25]
          fs_ff <= 1'b0;
        end
        else if (tick)
        begin
          fs_ff <= start; // [RULE17]
          if (start) frm_ff <= chans_ff;
          if (start || busy)
          begin
            st_ff <= DAR_PST_SEND;
            widx_ff <= nxt_widx;
            cidx_ff <= nxt_cidx;
            data_ff <= nxt_data; // [RULE12] [RULE13]
          end
          else
          begin
            st_ff <= DAR_PST_IDLE;
            data_ff <= 16'h0000;
          end
        end
      end
    end
  end

  assign port_a_data_out = g_port[0].data_ff;
  assign port_b_data_out = g_port[1].data_ff;
  assign port_c_data_out = g_port[2].data_ff;
  assign port_d_data_out = g_port[3].data_ff; // [RULE13]
  assign port_divided_clock = {g_port[3].ck_ff, g_port[2].ck_ff, g_port[1].ck_ff, g_port[0].ck_ff};
  assign port_frame_strobe = {g_port[3].fs_ff, g_port[2].fs_ff, g_port[1].fs_ff, g_port[0].fs_ff};

endmodule

// ===== verif/dar_top_asserts.sv
// Port timing checker for the receive back end
`timescale 1ns/1ps
module dar_top_chk (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [15:0] port_a_data_out,
  input wire logic [15:0] port_d_data_out,
  input wire logic [3:0] port_divided_clock,
  input wire logic [3:0] port_frame_strobe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  // Divide by four is kept all run: two cycles high, two low
  sequence sq_sck(b);
    b [*2] ##1 !b [*2] ##1 b;
  endsequence
  reset_quiet_a: assert property (
    $fell(reset) |-> (port_a_data_out | port_d_data_out) == 16'h0000)
    else $error("port data not low after reset");
  clock_hold_a: assert property (
    $fell(reset) |-> (port_divided_clock == 4'h0 && port_frame_strobe == 4'h0) [*5])
    else $error("port clock or strobe active before valid");
  sck_a_period_a: assert property (
    $rose(port_divided_clock[0]) |-> sq_sck(port_divided_clock[0]))
    else $error("port A clock period wrong");
  sck_d_period_a: assert property (
    $rose(port_divided_clock[3]) |-> sq_sck(port_divided_clock[3]))
    else $error("port D clock period wrong");
  strobe_width_a: assert property (
    $rose(port_frame_strobe[0]) |-> port_frame_strobe[0] [*4] ##1 !port_frame_strobe[0])
    else $error("frame strobe not one port period");
  strobe_edge_a: assert property (
    $rose(port_frame_strobe[0]) |-> $rose(port_divided_clock[0]))
    else $error("frame strobe off the port clock tick");
  strobe_d_edge_a: assert property (
    port_frame_strobe[3] && !$past(port_frame_strobe[3]) |->
      port_divided_clock[3] && !$past(port_divided_clock[3]))
    else $error("port D strobe off the port clock tick");
  data_tick_a: assert property (
    !$stable(port_a_data_out) |-> $rose(port_divided_clock[0]))
    else $error("port A data moved between ticks");
  data_d_tick_a: assert property (
    $changed(port_d_data_out) |-> $rose(port_divided_clock[3]))
    else $error("port D data moved between ticks");
endmodule

// ===== verif/dar_cap_model.sv
// Capture logic model that takes words off one output port
`timescale 1ns/1ps
module dar_cap (
  input wire logic sck,
  input wire logic fs,
  input wire logic [15:0] data,
  input wire logic [15:0] mask,
  input wire logic enable,
  input var int frame_len,
  output logic [16:0] cap_word,
  output int cap_count
);
  int left;
  initial
  begin
    cap_word = '0;
    cap_count = 0;
    left = 0;
  end
  // Polarity 0: data moves on the same mclk edge as the rise, so the fall is the safe edge
  always @(negedge sck)
  begin
    if (fs === 1'b1)
      left = frame_len;
    if (enable && left > 0)
    begin
      cap_word = {fs, data & mask};
      cap_count = cap_count + 1;
      left = left - 1;
    end
  end
endmodule

// ===== verif/dar_top_test.sv
// Self-checking bench for the receive back end
`timescale 1ns/1ps
`include "dar_map.svh"
module dar_top_test;
  import dar_pkg::*;
  logic mclk, reset, sample_valid, sample_is_q, gain_sync_pin, sck_sync_pin;
  logic reg_we, reg_re, re_d, cap_en, cap_d, pins16;
  logic [19:0] sample_in;
  dar_iq_s peer_b, peer_c, peer_d;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, cap_mask;
  logic [15:0] port_a_data_out, port_b_data_out, port_c_data_out, port_d_data_out;
  logic [3:0] port_divided_clock, port_frame_strobe;
  logic [16:0] cap_word;
  logic [16:0] dq[$];
  logic [15:0] rq[$];
  logic [31:0] seed = 32'h0001808C;
  logic [15:0] emb_i = 16'h0000;
  int cap_cnt, cap_len, mode, fail_count, num_checks;
  logic [15:0] rv [16] = '{16'h1000, 16'h0000, 16'hFF0F, 16'hF040, 16'h2244, 16'hFFFF,
    16'hFFFF, 16'h0008, 16'h0A48, 16'h0003, 16'h0003, 16'h0003, 16'h0003, 16'h0200,
    16'h0000, 16'h0000};

  dar_top i_dar_top (.mclk, .reset, .sample_in, .sample_valid, .sample_is_q, .peer_b,
    .peer_c, .peer_d, .gain_sync_pin, .sck_sync_pin, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .port_a_data_out, .port_b_data_out, .port_c_data_out,
    .port_d_data_out, .port_divided_clock, .port_frame_strobe);
  dar_cap i_dar_cap (.sck(port_divided_clock[cap_d ? 3 : 0]),
    .fs(port_frame_strobe[cap_d ? 3 : 0]),
    .data(cap_d ? port_d_data_out : port_a_data_out), .mask(cap_mask), .enable(cap_en),
    .frame_len(cap_len), .cap_word(cap_word), .cap_count(cap_cnt));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Gain, saturation, then round half to even at precision p
  function automatic logic [15:0] wrd(input logic [19:0] x, input int gn, input int p);
    int v;
    int d;
    int r;
    v = int'(signed'(x)) * gn;
    if (v > 524287) v = 524287;
    if (v < -524288) v = -524288;
    d = 20 - p;
    r = v & ((1 << d) - 1);
    v = v >>> d;
    if (d > 0 && (r > (1 << d) / 2 || (r == (1 << d) / 2 && v[0])))
      v++;
    if (v > (1 << (p - 1)) - 1)
      v = (1 << (p - 1)) - 1;
    return 16'((v <<< d) >>> 4);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (fail_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    rq.push_back(e);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
  endtask

  task automatic smp(input logic [19:0] x, input logic q);
    @(posedge mclk);
    sample_in <= x;
    sample_valid <= 1'b1;
    sample_is_q <= q;
    @(posedge mclk);
    sample_valid <= 1'b0;
  endtask

  task automatic agc(input logic [19:0] x);
    smp(x, 1'b0);
    repeat (6) @(posedge mclk);
  endtask

  // Narrow ports carry a word as two chunks on the low pins, high part first
  task automatic push_w(input logic [15:0] w, input logic f);
    if (pins16)
      dq.push_back({f, w});
    else
    begin
      dq.push_back({f, 8'h00, w[15:8]});
      dq.push_back({1'b0, 8'h00, w[7:0]});
    end
  endtask

  task automatic cfg(input logic [15:0] f, input int m, input logic p, input int n,
    input logic d);
    wr(5'h08, f);
    mode = m;
    pins16 = p;
    cap_len = n;
    cap_d <= d;
    cap_mask <= p ? 16'hFFFF : 16'h00FF;
  endtask

  task automatic pair(input logic [19:0] i, input logic [19:0] q, input int gn,
    input int p);
    dar_iq_s pb;
    dar_iq_s pc;
    dar_iq_s pd;
    pb = 40'({rnd(), rnd()});
    pc = 40'({rnd(), rnd()});
    pd = 40'({rnd(), rnd()});
    peer_b <= pb;
    peer_c <= pc;
    peer_d <= pd;
    if (mode == 3)
    begin
      push_w(pd.q[19:4], 1'b1);
      push_w(pc.i[19:4], 1'b0);
      push_w(pb.q[19:4], 1'b0);
      push_w(wrd(i, gn, p), 1'b0);
    end
    else if (mode == 2)
    begin
      push_w(pd.i[19:4], 1'b1);
      push_w(pd.q[19:4], 1'b0);
      push_w(pc.i[19:4], 1'b0);
      push_w(pc.q[19:4], 1'b0);
      push_w(pb.i[19:4], 1'b0);
      push_w(pb.q[19:4], 1'b0);
      push_w(wrd(i, gn, p), 1'b0);
      push_w(wrd(q, gn, p), 1'b0);
    end
    else
    begin
      push_w(wrd(i, gn, p) | emb_i, 1'b1);
      if (mode == 1)
        push_w(wrd(q, gn, p), 1'b0);
    end
    smp(i, 1'b0);
    smp(q, 1'b1);
    repeat (60) @(posedge mclk);
  endtask

  always @(posedge mclk)
    re_d <= reg_re;

  always @(negedge mclk)
    if (re_d)
      check({16'h0000, reg_rdata}, rq.size() > 0 ? {16'h0000, rq.pop_front()} : 32'hFFFFFFFF);

  always @(cap_cnt)
    if (cap_cnt > 0)
      check({15'h0000, cap_word}, dq.size() > 0 ? {15'h0000, dq.pop_front()} : 32'hFFFFFFFF);

  // Whole run needs about 840 cycles
  initial
  begin
    repeat (20000) @(posedge mclk);
    fail_count++;
    stop_test();
  end

  initial
  begin
    {reset, sample_valid, sample_is_q, gain_sync_pin, sck_sync_pin} = 5'h10;
    {reg_we, reg_re, re_d, cap_en, cap_d, pins16} = 6'h04;
    {sample_in, peer_b, peer_c, peer_d, reg_addr, reg_wdata} = '0;
    {cap_mask, cap_len, mode} = '0;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    sck_sync_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    sck_sync_pin <= 1'b0;
    for (int k = 0; k < 16; k++)
      rd(5'(k), rv[k]);
    wr(5'h1F, 16'hFFFF);
    rd(5'h1F, 16'h0000);
    cfg(16'h0A39, 1, 1'b1, 2, 1'b0);
    repeat (3) pair(20'(rnd()), 20'(rnd()), 1, 20);
    wr(5'h00, 16'h2000);
    rd(5'h0D, 16'h0400);
    pair(20'h40000, 20'hFFF00, 2, 20);
    wr(5'h00, 16'h1000);
    cfg(16'h0A38, 0, 1'b1, 1, 1'b0);
    pair(20'(rnd()), 20'(rnd()), 1, 20);
    cfg(16'h0435, 1, 1'b0, 4, 1'b0);
    pair(20'h01880, 20'h02800, 1, 8);
    pair(20'h01800, 20'(rnd()), 1, 8);
    cfg(16'h1439, 1, 1'b1, 2, 1'b0);
    emb_i = 16'h0002;
    pair(20'h01800, 20'h02800, 1, 8);
    emb_i = 16'h0000;
    cfg(16'h0A3A, 2, 1'b1, 8, 1'b1);
    repeat (2) pair(20'(rnd()), 20'(rnd()), 1, 20);
    cfg(16'h2A3A, 3, 1'b1, 4, 1'b1);
    pair(20'(rnd()), 20'(rnd()), 1, 20);
    cap_en <= 1'b0;
    wr(5'h05, 16'h0000);
    wr(5'h02, 16'hFFF0);
    agc(20'h00100);
    agc(20'h00100);
    rd(5'h0D, 16'h0204);
    wr(5'h02, 16'hFFF1);
    agc(20'h00100);
    rd(5'h0D, 16'h0204);
    gain_sync_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    gain_sync_pin <= 1'b0;
    rd(5'h0D, 16'h0200);
    wr(5'h05, 16'hFFFF);
    wr(5'h02, 16'hFFF0);
    agc(20'h40000);
    rd(5'h0D, 16'h01FC);
    repeat (20) @(posedge mclk);
    check(32'(dq.size()), 32'h0);
    check(32'(rq.size()), 32'h0);
    stop_test();
  end
endmodule

bind dar_top dar_top_chk i_dar_top_chk (.mclk(mclk), .reset(reset),
  .port_a_data_out(port_a_data_out), .port_d_data_out(port_d_data_out),
  .port_divided_clock(port_divided_clock), .port_frame_strobe(port_frame_strobe));
